// ===== shared/srkp_pkg.sv
package srkp_pkg;

  // serial word framing
  localparam logic [4:0]  WORD_BITS     = 5'h10;
  localparam logic [4:0]  TURN_BIT      = 5'h08;

  // instruction codes in the upper byte
  localparam logic [7:0]  OP_RAM_WR     = 8'h98;
  localparam logic [7:0]  OP_SET_CHAR   = 8'h93;
  localparam logic [7:0]  OP_SET_GLYPH  = 8'h90;
  // key read code sits outside the known table; plain default
  localparam logic [7:0]  OP_KEY_RD     = 8'h9f;

  // shared char / icon address map
  localparam logic [7:0]  CHAR_FIRST    = 8'h00;
  localparam logic [7:0]  CHAR_LAST     = 8'h0d;
  localparam logic [7:0]  ICON_FIRST    = 8'h10;
  localparam logic [7:0]  ICON_SHOWN    = 8'h1b;
  localparam logic [7:0]  ICON_LAST     = 8'h1d;
  localparam logic [7:0]  CHAR_ADDR_MSK = 8'h1f;

  // reset values
  localparam logic [7:0]  AC_RST        = 8'h00;
  localparam logic [7:0]  KEY_RST       = 8'h00;

  // timing
  localparam int          CLK_NS        = 10;
  localparam int          FRAME_NS      = 12360000;
  localparam int          KS_BUSY_NS    = 220700;
  localparam int          FRAME_CYC     = FRAME_NS / CLK_NS;
  localparam int          KS_BUSY_CYC   = KS_BUSY_NS / CLK_NS;
  localparam int          FRAME_W       = 21;

  typedef enum logic [1:0] {
    TGT_NONE,
    TGT_CHAR,
    TGT_ICON,
    TGT_GLYPH
  } srkp_tgt_e;

  typedef struct packed {
    logic             sel_s1;
    logic             sel_s2;
    logic             sel_prev;
    logic             tog_s1;
    logic             tog_s2;
    logic             tog_seen;
    logic             lrst;
    logic [7:0]       ac;
    logic             glyph_sel;
    logic [7:0]       key_hold;
    logic             wr;
    srkp_tgt_e        wr_tgt;
    logic [7:0]       wr_addr;
    logic [7:0]       wr_data;
    logic             shift;
    logic [20:0]      frame_cnt;
    logic             busy;
  } srkp_core_s;

  typedef struct packed {
    logic [15:0]      sr;
    logic             tog;
  } srkp_pos_s;

  typedef struct packed {
    logic             oe;
    logic             dout;
    logic [2:0]       idx;
  } srkp_neg_s;

endpackage

// ===== rtl/srkp_link_rx.sv
`timescale 1ns/1ps
module srkp_link_rx (
  input  wire logic        sclk,
  input  wire logic        select_low_input,
  input  wire logic        link_rst_n,
  input  wire logic        sdata_i,
  input  wire logic [7:0]  key_hold,
  output logic             sdata_o,
  output logic             sdata_oe,
  output logic [15:0]      word,
  output logic             word_tog
);

  logic [4:0]           cnt_q;
  logic [4:0]           cnt_d;
  srkp_pkg::srkp_pos_s  pos_q;
  srkp_pkg::srkp_pos_s  pos_d;
  srkp_pkg::srkp_neg_s  neg_q;
  srkp_pkg::srkp_neg_s  neg_d;

  ////////////////////////////////////////////////////////////////////////////
  // sclk stops between frames, so select itself clears the counter
  always_ff @(posedge sclk or posedge select_low_input or negedge link_rst_n)
  begin
    if (!link_rst_n)
      cnt_q <= 5'h00;
    else if (select_low_input)
      cnt_q <= 5'h00;
    else
      cnt_q <= cnt_d;
  end

  always_comb
  begin
    cnt_d = cnt_q;
    pos_d = pos_q;
    if (!select_low_input && cnt_q < srkp_pkg::WORD_BITS)
    begin
      pos_d.sr = {pos_q.sr[14:0], sdata_i};
      cnt_d    = cnt_q + 5'h01;
      if (cnt_q == srkp_pkg::WORD_BITS - 5'h01)
        pos_d.tog = ~pos_q.tog;
    end
  end

  // word is kept past select rise; core reads it after the toggle
  always_ff @(posedge sclk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      pos_q <= '0;
    else
      pos_q <= pos_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output side on the falling edge
  always_comb
  begin
    neg_d = neg_q;
    if (!neg_q.oe)
    begin
      if (cnt_q == srkp_pkg::TURN_BIT && pos_q.sr[7:0] == srkp_pkg::OP_KEY_RD)
      begin
        neg_d.oe   = 1'b1;
        neg_d.dout = key_hold[7];
        neg_d.idx  = 3'h6;
      end
    end
    else
    begin
      neg_d.dout = key_hold[neg_q.idx];
      neg_d.idx  = neg_q.idx - 3'h1;
    end
  end

  always_ff @(negedge sclk or posedge select_low_input or negedge link_rst_n)
  begin
    if (!link_rst_n)
      neg_q <= '0;
    else if (select_low_input)
      neg_q <= '0;
    else
      neg_q <= neg_d;
  end

  assign sdata_o  = neg_q.dout;
  assign sdata_oe = neg_q.oe;
  assign word     = pos_q.sr;
  assign word_tog = pos_q.tog;

  ////////////////////////////////////////////////////////////////////////////
  turn_at_eight_a: assert property (
    @(negedge sclk) disable iff (select_low_input || !link_rst_n)
    $rose(neg_q.oe) |-> ($past(cnt_q) == srkp_pkg::TURN_BIT
      && $past(pos_q.sr[7:0]) == srkp_pkg::OP_KEY_RD))
    else $error("data line turned at wrong bit");

  word_frozen_a: assert property (
    @(posedge sclk) disable iff (select_low_input || !link_rst_n)
    (cnt_q == srkp_pkg::WORD_BITS) |=> $stable(pos_q.sr) && cnt_q == srkp_pkg::WORD_BITS)
    else $error("bits past sixteen changed word");

  msb_first_a: assert property (
    @(posedge sclk) disable iff (select_low_input || !link_rst_n)
    (cnt_q < srkp_pkg::WORD_BITS) |=> pos_q.sr[0] == $past(sdata_i)
      && pos_q.sr[15:1] == $past(pos_q.sr[14:0]))
    else $error("shift order broken");

endmodule

// ===== rtl/srkp_store.sv
`timescale 1ns/1ps
module srkp_store (
  input  wire logic              mclk,
  input  wire logic              we,
  input  srkp_pkg::srkp_tgt_e    tgt,
  input  wire logic [7:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic [3:0]        char_raddr,
  input  wire logic [3:0]        icon_raddr,
  input  wire logic [7:0]        glyph_raddr,
  output logic [7:0]             char_rdata,
  output logic [4:0]             icon_rdata,
  output logic [4:0]             glyph_rdata
);

  logic [7:0] char_mem  [0:13];
  logic [4:0] icon_mem  [0:11];
  logic [4:0] glyph_mem [0:255];

  // contents have no reset; software fills them after power up
  always_ff @(posedge mclk)
  begin
    if (we && tgt == srkp_pkg::TGT_CHAR)
      char_mem[addr[3:0]] <= wdata;
    if (we && tgt == srkp_pkg::TGT_ICON)
      icon_mem[addr[3:0]] <= wdata[4:0];
    if (we && tgt == srkp_pkg::TGT_GLYPH)
      glyph_mem[addr] <= wdata[4:0];
    char_rdata  <= (char_raddr < 4'he) ? char_mem[char_raddr] : 8'h00;
    icon_rdata  <= (icon_raddr < 4'hc) ? icon_mem[icon_raddr] : 5'h00;
    glyph_rdata <= glyph_mem[glyph_raddr];
  end

endmodule

// ===== rtl/srkp_core.sv
`timescale 1ns/1ps
module srkp_core #(
  parameter int FRAME_CYC   = srkp_pkg::FRAME_CYC,
  parameter int KS_BUSY_CYC = srkp_pkg::KS_BUSY_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        sclk,
  input  wire logic        select_low_input,
  input  wire logic        sdata_i,
  output logic             sdata_o,
  output logic             sdata_oe,
  input  wire logic [7:0]  key_data,
  input  wire logic        entry_incr,
  input  wire logic        entry_shift,
  input  wire logic        keyscan_on,
  input  wire logic [3:0]  char_raddr,
  input  wire logic [3:0]  icon_raddr,
  input  wire logic [7:0]  glyph_raddr,
  output logic [7:0]       char_rdata,
  output logic [4:0]       icon_rdata,
  output logic [4:0]       glyph_rdata,
  output logic             display_shift,
  output logic             shift_toward_left,
  output logic             keyscan_busy,
  output logic [7:0]       address_counter,
  output logic             glyph_select
);

  srkp_pkg::srkp_core_s  q;
  srkp_pkg::srkp_core_s  d;
  logic [15:0]           link_word;
  logic                  link_tog;
  logic                  sel_rise;
  logic                  word_full;
  logic [7:0]            op;
  logic [7:0]            arg;
  logic                  do_exec;

  localparam logic [20:0] FRAME_END = 21'(FRAME_CYC - 1);
  localparam logic [20:0] BUSY_END  = 21'(KS_BUSY_CYC);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] step_addr(input logic [7:0] a,
                                           input logic       up,
                                           input logic       glyph);
    logic [7:0] s;
    s = up ? a + 8'h01 : a - 8'h01;
    return glyph ? s : (s & srkp_pkg::CHAR_ADDR_MSK);
  endfunction

  function automatic srkp_pkg::srkp_tgt_e char_icon_tgt(input logic [7:0] a);
    srkp_pkg::srkp_tgt_e t;
    t = srkp_pkg::TGT_NONE;
    if (a <= srkp_pkg::CHAR_LAST)
      t = srkp_pkg::TGT_CHAR;
    else if (a >= srkp_pkg::ICON_FIRST && a <= srkp_pkg::ICON_SHOWN)
      t = srkp_pkg::TGT_ICON;
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  srkp_link_rx u_link (
    .sclk             (sclk),
    .select_low_input (select_low_input),
    .link_rst_n       (q.lrst),
    .sdata_i          (sdata_i),
    .key_hold         (q.key_hold),
    .sdata_o          (sdata_o),
    .sdata_oe         (sdata_oe),
    .word             (link_word),
    .word_tog         (link_tog)
  );

  srkp_store u_store (
    .mclk        (mclk),
    .we          (q.wr),
    .tgt         (q.wr_tgt),
    .addr        (q.wr_addr),
    .wdata       (q.wr_data),
    .char_raddr  (char_raddr),
    .icon_raddr  (icon_raddr),
    .glyph_raddr (glyph_raddr),
    .char_rdata  (char_rdata),
    .icon_rdata  (icon_rdata),
    .glyph_rdata (glyph_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // both chains are two flops long, so the word toggle is never later
  // than the select rise it belongs to
  assign sel_rise  = q.sel_s2 & ~q.sel_prev;
  assign word_full = q.tog_s2 != q.tog_seen;
  assign op        = link_word[15:8];
  assign arg       = link_word[7:0];
  assign do_exec   = sel_rise & word_full;

  always_comb
  begin
    d          = q;
    d.sel_s1   = select_low_input;
    d.sel_s2   = q.sel_s1;
    d.sel_prev = q.sel_s2;
    d.tog_s1   = link_tog;
    d.tog_s2   = q.tog_s1;
    d.lrst     = 1'b1;
    d.wr       = 1'b0;
    d.shift    = 1'b0;
    // key data only moves while the link is idle, so it is still in frame
    if (q.sel_s2)
      d.key_hold = key_data;
    if (sel_rise)
      d.tog_seen = q.tog_s2;
    if (do_exec)
    begin
      if (op == srkp_pkg::OP_SET_CHAR)
      begin
        d.ac        = {3'h0, arg[4:0]};
        d.glyph_sel = 1'b0;
      end
      else if (op == srkp_pkg::OP_SET_GLYPH)
      begin
        d.ac        = arg;
        d.glyph_sel = 1'b1;
      end
      else if (op == srkp_pkg::OP_RAM_WR)
      begin
        d.wr_addr = q.ac;
        if (q.glyph_sel)
        begin
          d.wr_tgt  = srkp_pkg::TGT_GLYPH;
          d.wr_data = {3'h0, arg[4:0]};
        end
        else
        begin
          d.wr_tgt  = char_icon_tgt(q.ac);
          d.wr_data = (char_icon_tgt(q.ac) == srkp_pkg::TGT_CHAR) ? arg
                                                                  : {3'h0, arg[4:0]};
        end
        d.wr    = q.glyph_sel || char_icon_tgt(q.ac) != srkp_pkg::TGT_NONE;
        d.ac    = step_addr(q.ac, entry_incr, q.glyph_sel);
        d.shift = entry_shift;
      end
    end
    // keyscan busy window at the head of each frame
    if (q.frame_cnt == FRAME_END)
      d.frame_cnt = 21'h000000;
    else
      d.frame_cnt = q.frame_cnt + 21'h000001;
    if (q.frame_cnt == FRAME_END)
      d.busy = keyscan_on;
    else if (q.frame_cnt == BUSY_END - 21'h000001)
      d.busy = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      q           <= '0;
      q.sel_s1    <= 1'b1;
      q.sel_s2    <= 1'b1;
      q.sel_prev  <= 1'b1;
      q.ac        <= srkp_pkg::AC_RST;
      q.key_hold  <= srkp_pkg::KEY_RST;
      q.wr_tgt    <= srkp_pkg::TGT_NONE;
    end
    else
      q <= d;
  end

  assign display_shift     = q.shift;
  assign shift_toward_left = entry_incr;
  assign keyscan_busy      = q.busy;
  assign address_counter   = q.ac;
  assign glyph_select      = q.glyph_sel;

  ////////////////////////////////////////////////////////////////////////////
  char_full_byte_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op == srkp_pkg::OP_RAM_WR && !q.glyph_sel && q.ac <= srkp_pkg::CHAR_LAST)
    |=> q.wr && q.wr_tgt == srkp_pkg::TGT_CHAR && q.wr_data == $past(arg))
    else $error("char write lost bits");

  five_bit_mask_a: assert property (@(posedge mclk) disable iff (!rstn)
    (q.wr && q.wr_tgt != srkp_pkg::TGT_CHAR) |-> q.wr_data[7:5] == 3'h0)
    else $error("upper bits leaked into small ram");

  target_select_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op == srkp_pkg::OP_SET_GLYPH) |=> q.glyph_sel ##0
      (!do_exec || op != srkp_pkg::OP_SET_CHAR) [*1] ##1 q.glyph_sel)
    else $error("target ram not taken from address set");

  addr_step_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op == srkp_pkg::OP_RAM_WR && q.glyph_sel)
    |=> q.ac == ($past(entry_incr) ? $past(q.ac) + 8'h01 : $past(q.ac) - 8'h01))
    else $error("address did not step by one");

  write_shift_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op == srkp_pkg::OP_RAM_WR) |=> display_shift == $past(entry_shift))
    else $error("display shift not applied");

  icon_hidden_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op == srkp_pkg::OP_RAM_WR && !q.glyph_sel && q.ac > srkp_pkg::ICON_SHOWN)
    |=> !q.wr && q.ac != $past(q.ac))
    else $error("hidden icon write misbehaved");

  short_drop_a: assert property (@(posedge mclk) disable iff (!rstn)
    (sel_rise && !word_full) |=> !q.wr && $stable(q.ac) && $stable(q.glyph_sel))
    else $error("short transfer executed");

  exec_on_rise_a: assert property (@(posedge mclk) disable iff (!rstn)
    q.wr |-> $past(sel_rise) && $past(word_full))
    else $error("write without closing select edge");

  busy_length_a: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(q.busy) |-> q.frame_cnt == BUSY_END)
    else $error("keyscan busy length wrong");

  set_char_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op == srkp_pkg::OP_SET_CHAR)
    |=> q.ac == {3'h0, $past(arg[4:0])} && !q.glyph_sel)
    else $error("char address set wrong");

  set_glyph_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op == srkp_pkg::OP_SET_GLYPH) |=> q.ac == $past(arg) && q.glyph_sel)
    else $error("glyph address set wrong");

  char_span_a: assert property (@(posedge mclk) disable iff (!rstn)
    !q.glyph_sel |-> q.ac <= srkp_pkg::CHAR_ADDR_MSK)
    else $error("char counter left five bits");

  icon_store_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op == srkp_pkg::OP_RAM_WR && !q.glyph_sel
      && q.ac >= srkp_pkg::ICON_FIRST && q.ac <= srkp_pkg::ICON_SHOWN)
    |=> q.wr && q.wr_tgt == srkp_pkg::TGT_ICON && q.wr_data == {3'h0, $past(arg[4:0])})
    else $error("icon write lost or widened");

  glyph_store_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op == srkp_pkg::OP_RAM_WR && q.glyph_sel)
    |=> q.wr && q.wr_tgt == srkp_pkg::TGT_GLYPH && q.wr_data == {3'h0, $past(arg[4:0])})
    else $error("glyph write lost or widened");

  write_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op == srkp_pkg::OP_RAM_WR) |=> q.wr_addr == $past(q.ac))
    else $error("write went to wrong address");

  char_step_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op == srkp_pkg::OP_RAM_WR && !q.glyph_sel)
    |=> q.ac == (($past(entry_incr) ? $past(q.ac) + 8'h01 : $past(q.ac) - 8'h01)
      & srkp_pkg::CHAR_ADDR_MSK))
    else $error("char address did not step");

  shift_only_write_a: assert property (@(posedge mclk) disable iff (!rstn)
    display_shift |-> $past(do_exec) && $past(op) == srkp_pkg::OP_RAM_WR)
    else $error("display shift without a write");

  icon_top_a: assert property (@(posedge mclk) disable iff (!rstn)
    (q.wr && q.wr_tgt == srkp_pkg::TGT_ICON) |-> q.wr_addr <= srkp_pkg::ICON_SHOWN
      && q.wr_addr >= srkp_pkg::ICON_FIRST)
    else $error("hidden icon cell written");

  unknown_op_a: assert property (@(posedge mclk) disable iff (!rstn)
    (do_exec && op != srkp_pkg::OP_RAM_WR && op != srkp_pkg::OP_SET_CHAR
      && op != srkp_pkg::OP_SET_GLYPH)
    |=> !q.wr && $stable(q.ac) && $stable(q.glyph_sel))
    else $error("unknown code had an effect");

  no_exec_no_write_a: assert property (@(posedge mclk) disable iff (!rstn)
    !do_exec |=> !q.wr && !display_shift)
    else $error("write without a complete word");

  word_consumed_a: assert property (@(posedge mclk) disable iff (!rstn)
    sel_rise |=> !word_full)
    else $error("word left pending after select rise");

  key_capture_a: assert property (@(posedge mclk) disable iff (!rstn)
    q.sel_s2 |=> q.key_hold == $past(key_data))
    else $error("key data not captured while idle");

  key_frozen_a: assert property (@(posedge mclk) disable iff (!rstn)
    !q.sel_s2 |=> $stable(q.key_hold))
    else $error("key data moved during a frame");

  busy_start_a: assert property (@(posedge mclk) disable iff (!rstn)
    (q.frame_cnt == FRAME_END) |=> q.frame_cnt == 21'h000000 && q.busy == $past(keyscan_on))
    else $error("frame did not wrap into busy");

  busy_window_a: assert property (@(posedge mclk) disable iff (!rstn)
    q.busy |-> q.frame_cnt < BUSY_END)
    else $error("keyscan busy outside its window");

  frame_bound_a: assert property (@(posedge mclk) disable iff (!rstn)
    q.frame_cnt <= FRAME_END)
    else $error("frame counter overran");

endmodule

// ===== sim/srkp_host_model.sv
`timescale 1ns/1ps
module srkp_host_model (
  output logic       sclk,
  output logic       select_low_input,
  output logic       sdata_i,
  input  wire logic  sdata_o,
  input  wire logic  sdata_oe
);
  logic drv;
  logic dval;

  // pull-up on the line; both driving shows as unknown so contention is caught
  assign sdata_i = (sdata_oe && drv) ? 1'bx : sdata_oe ? sdata_o : drv ? dval : 1'b1;

  initial
  begin
    sclk = 1'b0;
    select_low_input = 1'b1;
    drv = 1'b0;
    dval = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock idles low and runs only inside a frame; bits past 16 are filler
  task automatic send(input logic [15:0] w, input int n);
    select_low_input = 1'b0;
    drv = 1'b1;
    #40;
    for (int i = 0; i < n; i++)
    begin
      dval = (i < 16) ? w[15 - i] : i[0];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    #40 select_low_input = 1'b1;
    drv = 1'b0;
    #500;
  endtask

  // key read: only the opcode byte is driven, line let go before the 8th fall
  task automatic key_read(input logic [7:0] op, output logic [7:0] key);
    select_low_input = 1'b0;
    drv = 1'b1;
    key = 8'h00;
    #40;
    for (int i = 0; i < 16; i++)
    begin
      if (i < 8)
        dval = op[7 - i];
      #62.5 sclk = 1'b1;
      if (i > 7)
        key = {key[6:0], sdata_i};
      #20 if (i == 7) drv = 1'b0;
      #42.5 sclk = 1'b0;
    end
    #40 select_low_input = 1'b1;
    #500;
  endtask

  // activity while deselected, which the port must not take in
  task automatic junk(input int n);
    drv = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      dval = i[0];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    drv = 1'b0;
    #500;
  endtask
endmodule

// ===== sim/serial_ram_write_key_read_port_tb_top.sv
`timescale 1ns/1ps
module serial_ram_write_key_read_port_tb_top;
  logic        mclk, rstn, sclk, select_low_input, sdata_i, sdata_o, sdata_oe;
  logic        entry_incr, entry_shift, keyscan_on, display_shift;
  logic        shift_toward_left, keyscan_busy, glyph_select;
  logic [7:0]  key_data, glyph_raddr, char_rdata, address_counter;
  logic [3:0]  char_raddr, icon_raddr;
  logic [4:0]  icon_rdata, glyph_rdata;
  logic [7:0]  k;
  int          fails = 0;
  int          samples_checked = 0;
  int          shifts = 0;
  int          s;

  srkp_core #(.FRAME_CYC(200), .KS_BUSY_CYC(20)) i_srkp_core (
    .mclk, .rstn, .sclk, .select_low_input, .sdata_i, .sdata_o, .sdata_oe,
    .key_data, .entry_incr, .entry_shift, .keyscan_on, .char_raddr,
    .icon_raddr, .glyph_raddr, .char_rdata, .icon_rdata, .glyph_rdata,
    .display_shift, .shift_toward_left, .keyscan_busy, .address_counter,
    .glyph_select
  );

  srkp_host_model i_srkp_host_model (
    .sclk, .select_low_input, .sdata_i, .sdata_o, .sdata_oe
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // shift output is a one-cycle pulse, so count it every edge
  always @(posedge mclk)
    if (display_shift === 1'b1)
      shifts <= shifts + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input int t, input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    char_raddr = a[3:0];
    icon_raddr = a[3:0];
    glyph_raddr = a;
    repeat (2) @(negedge mclk);
    chk("ram read", {8'h00, e}, t == 0 ? {8'h00, char_rdata} :
        t == 1 ? {11'h000, icon_rdata} : {11'h000, glyph_rdata});
  endtask

  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    i_srkp_host_model.send({op, d}, 16);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_char();
    wr(srkp_pkg::OP_SET_CHAR, 8'h0d);
    chk("ac after set", 16'h000d, 16'(address_counter));
    s = shifts;
    wr(srkp_pkg::OP_RAM_WR, 8'ha5);
    rd(0, 8'h0d, 8'ha5);
    chk("ac step up", 16'h000e, 16'(address_counter));
    chk("shift pulses", 16'h0001, 16'(shifts - s));
    chk("shift dir", 16'h0001, 16'(shift_toward_left));
  endtask

  task automatic t_icon();
    @(negedge mclk) entry_incr = 1'b0;
    wr(srkp_pkg::OP_SET_CHAR, 8'h10);
    wr(srkp_pkg::OP_RAM_WR, 8'hff);
    rd(1, 8'h00, 8'h1f);
    chk("ac step down", 16'h000f, 16'(address_counter));
    wr(srkp_pkg::OP_SET_CHAR, 8'h1c);
    wr(srkp_pkg::OP_RAM_WR, 8'h1f);
    chk("ac after 1c", 16'h001b, 16'(address_counter));
    rd(1, 8'h0c, 8'h00);
  endtask

  task automatic t_glyph();
    @(negedge mclk) entry_incr = 1'b1;
    wr(srkp_pkg::OP_SET_GLYPH, 8'h40);
    chk("glyph select", 16'h0001, 16'(glyph_select));
    wr(srkp_pkg::OP_RAM_WR, 8'he7);
    rd(2, 8'h40, 8'h07);
    rd(0, 8'h0d, 8'ha5);
    chk("ac glyph", 16'h0041, 16'(address_counter));
    wr(srkp_pkg::OP_SET_CHAR, 8'h05);
    chk("char select", 16'h0000, 16'(glyph_select));
    wr(srkp_pkg::OP_RAM_WR, 8'h3c);
    rd(0, 8'h05, 8'h3c);
  endtask

  task automatic t_frames();
    s = shifts;
    i_srkp_host_model.send({srkp_pkg::OP_RAM_WR, 8'h11}, 15);
    chk("ac short", 16'h0006, 16'(address_counter));
    chk("short shifts", 16'h0000, 16'(shifts - s));
    i_srkp_host_model.send({srkp_pkg::OP_RAM_WR, 8'h77}, 20);
    rd(0, 8'h06, 8'h77);
    chk("ac long", 16'h0007, 16'(address_counter));
    i_srkp_host_model.junk(20);
    chk("ac idle", 16'h0007, 16'(address_counter));
  endtask

  task automatic t_key();
    @(negedge mclk) key_data = 8'hb4;
    repeat (5) @(negedge mclk);
    i_srkp_host_model.key_read(srkp_pkg::OP_KEY_RD, k);
    chk("key bits", 16'h00b4, 16'(k));
    chk("line released", 16'h0000, 16'(sdata_oe));
    chk("ac key", 16'h0007, 16'(address_counter));
    @(negedge mclk) entry_shift = 1'b0;
    s = shifts;
    wr(srkp_pkg::OP_RAM_WR, 8'h5a);
    rd(0, 8'h07, 8'h5a);
    chk("shift off", 16'h0000, 16'(shifts - s));
  endtask

  task automatic t_busy();
    s = 0;
    repeat (1000)
    begin
      @(negedge mclk);
      if (keyscan_busy === 1'b1)
        s++;
    end
    chk("busy cycles", 16'h0064, 16'(s));
    // one frame to let a running window close, then none may start
    @(negedge mclk) keyscan_on = 1'b0;
    repeat (200) @(negedge mclk);
    s = 0;
    repeat (200)
    begin
      @(negedge mclk);
      if (keyscan_busy !== 1'b0)
        s++;
    end
    chk("busy off", 16'h0000, 16'(s));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    key_data = 8'h00;
    entry_incr = 1'b1;
    entry_shift = 1'b1;
    keyscan_on = 1'b1;
    char_raddr = 4'h0;
    icon_raddr = 4'h0;
    glyph_raddr = 8'h00;
    repeat (19) @(negedge mclk);
    chk("rst ac", 16'h0000, 16'(address_counter));
    chk("rst oe", 16'h0000, 16'(sdata_oe));
    chk("rst busy", 16'h0000, 16'(keyscan_busy));
    @(negedge mclk) rstn = 1'b1;
    repeat (5) @(negedge mclk);
    t_char();
    t_icon();
    t_glyph();
    t_frames();
    t_key();
    t_busy();
    conclude();
  end

  initial
  begin
    #300000;
    fails++;
    conclude();
  end
endmodule
